//--- rtl/wake_event_pkg.sv
// Operation
// - Event level, or a ring input fall, sets flag; flag holds until cleared
// - First register is word bits 8-15, index 01h
// - Second register is word bits 16-23, index 02h
// - Port 4 pin 7 latched, programmable polarity, debounce
// - Port 4 pins 6-0 behave like pin 7
// - Write one clears flag, zero keeps it
// - All flags read zero after reset
// - Power button press sets bit 7, debounced
// - Power flag clear also clears fixed companion flag
// - Legacy mode: button power-off clears power flag
// - Sleep button press sets bit 6, debounced
// - Sleep flag clear also clears fixed companion flag
// - Key 3 sets bit 5, only in key mode
// - Key 2 sets bit 4, only in key mode
// - Keyboard mode event sets bit 3
// - Pointer event sets bit 2
// - Falling ring input B sets bit 1
// - Falling ring input A sets bit 0
package wake_event_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_GPIO_PORT4      = 8'h01;
  localparam logic [7:0]  IDX_BUTTONS_INPUTS  = 8'h02;
  localparam logic [7:0]  ADDR_GPIO_PORT4     = IDX_GPIO_PORT4 << 2;
  localparam logic [7:0]  ADDR_BUTTONS_INPUTS = IDX_BUTTONS_INPUTS << 2;
  localparam logic [7:0]  ADDR_CONTROL        = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_ENABLE     = 8'h10;
  localparam logic [7:0]  ADDR_IRQ_STATUS     = 8'h14;
  localparam logic [7:0]  ADDR_IRQ_CLEAR      = 8'h18;

  // Control register layout
  localparam int unsigned CTL_W               = 17;
  localparam int unsigned CTL_POL_LSB         = 0;
  localparam int unsigned CTL_DBEN_LSB        = 8;
  localparam int unsigned CTL_LEGACY_BIT      = 16;
  localparam logic [16:0] CTL_RESET           = 17'h000ff;

  // Flag positions inside the 16-bit status vector
  localparam int unsigned GPIO_PINS           = 8;
  localparam int unsigned BIT_RING_A          = 8;
  localparam int unsigned BIT_RING_B          = 9;
  localparam int unsigned BIT_POINTER         = 10;
  localparam int unsigned BIT_KEY1            = 11;
  localparam int unsigned BIT_KEY2            = 12;
  localparam int unsigned BIT_KEY3            = 13;
  localparam int unsigned BIT_SLEEP           = 14;
  localparam int unsigned BIT_POWER           = 15;
  localparam logic [15:0] STATUS_RESET        = 16'h0000;

  // Filter slots: port 4 pins, then the two buttons
  localparam int unsigned NUM_FILT            = 10;
  localparam int unsigned FLT_POWER           = 8;
  localparam int unsigned FLT_SLEEP           = 9;
  localparam logic [9:0]  FLT_RESET           = 10'h300;
  localparam logic [1:0]  RING_PREV_RESET     = 2'h3;

  // Debounce: least stable time, rounded up to cycles
  localparam int unsigned CLK_PERIOD_NS       = 20;
  localparam int unsigned DEBOUNCE_TIME_NS    = 1000000;
  localparam int unsigned DEBOUNCE_CYCLES     =
    (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : wake_event_pkg

//--- rtl/wake_event_status_regs.sv
// Design decision made here: register access over APB.
module wake_event_status_regs
  import wake_event_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES_P = DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Event sources
  input  wire logic [7:0]  port4_pin_input,
  input  wire logic        power_button_input_n,
  input  wire logic        sleep_button_input_n,
  input  wire logic        main_power_off_by_button,
  input  wire logic        kbd_pm_key_mode,
  input  wire logic        key3_event,
  input  wire logic        key2_event,
  input  wire logic        key1_event,
  input  wire logic        pointer_event,
  input  wire logic        ring_indicate_port_a,
  input  wire logic        ring_indicate_port_b,
  // Status and side effects
  output logic      [15:0] wake_status,
  output logic             clear_fixed_power_button_flag,
  output logic             clear_fixed_sleep_button_flag,
  output logic             irq
);

  localparam int unsigned CNT_W = $clog2(DEBOUNCE_CYCLES_P + 1);

  typedef struct packed {
    logic [NUM_FILT-1:0][CNT_W-1:0] cnt;
    logic [NUM_FILT-1:0]            flt;
    logic [1:0]                     ring_prev;
    logic [15:0]                    status;
    logic [15:0]                    irq_en;
    logic [15:0]                    irq_sts;
    logic [CTL_W-1:0]               ctl;
    logic [31:0]                    rdata;
    logic                           ready;
    logic                           slverr;
    logic                           irq;
    logic                           clr_pb;
    logic                           clr_sb;
  } state_t;

  state_t st_q;
  state_t st_d;

  logic [NUM_FILT-1:0]            raw;
  logic [NUM_FILT-1:0]            filt_on;
  logic [NUM_FILT-1:0]            differ;
  logic [NUM_FILT-1:0]            cnt_done;
  logic [NUM_FILT-1:0]            flt_d;
  logic [NUM_FILT-1:0][CNT_W-1:0] cnt_d;
  logic [15:0]                    set_v;
  logic [15:0]                    sw_clr;
  logic [15:0]                    hw_clr;
  logic [15:0]                    clr_v;
  logic [7:0]                     gpio_active;
  logic                           setup;
  logic                           wr;
  logic                           hit_a;
  logic                           hit_b;
  logic                           hit_ctl;
  logic                           hit_en;
  logic                           hit_sts;
  logic                           hit_clr;

  assign raw = {sleep_button_input_n, power_button_input_n, port4_pin_input};

  // Stable-time filters; a change only passes after a full quiet period, except on port 4 pins with debounce off
  for (genvar i = 0; i < NUM_FILT; i++) begin : g_flt
    if (i < GPIO_PINS) begin : g_opt
      assign filt_on[i] = st_q.ctl[CTL_DBEN_LSB + i];
    end else begin : g_fix
      assign filt_on[i] = 1'b1;
    end
    assign differ[i]   = raw[i] != st_q.flt[i];
    assign cnt_done[i] = st_q.cnt[i] == CNT_W'(DEBOUNCE_CYCLES_P - 1);
    assign flt_d[i]    = (!filt_on[i] || (differ[i] && cnt_done[i])) ?
                         raw[i] : st_q.flt[i];
    assign cnt_d[i]    = (filt_on[i] && differ[i] && !cnt_done[i]) ?
                         CNT_W'(st_q.cnt[i] + 1'b1) : '0;
  end

  assign gpio_active = st_q.flt[GPIO_PINS-1:0] ~^ st_q.ctl[CTL_POL_LSB +: GPIO_PINS];

  always_comb begin
    set_v                = '0;
    set_v[7:0]           = gpio_active;
    set_v[BIT_POWER]     = !st_q.flt[FLT_POWER];
    set_v[BIT_SLEEP]     = !st_q.flt[FLT_SLEEP];
    set_v[BIT_KEY3]      = key3_event && kbd_pm_key_mode;
    set_v[BIT_KEY2]      = key2_event && kbd_pm_key_mode;
    set_v[BIT_KEY1]      = key1_event;
    set_v[BIT_POINTER]   = pointer_event;
    set_v[BIT_RING_B]    = st_q.ring_prev[1] && !ring_indicate_port_b;
    set_v[BIT_RING_A]    = st_q.ring_prev[0] && !ring_indicate_port_a;
  end

  // Bus decode; read data is captured in the setup cycle
  assign setup   = psel && !penable;
  assign wr      = psel && penable && st_q.ready && pwrite;
  assign hit_a   = paddr == ADDR_GPIO_PORT4;
  assign hit_b   = paddr == ADDR_BUTTONS_INPUTS;
  assign hit_ctl = paddr == ADDR_CONTROL;
  assign hit_en  = paddr == ADDR_IRQ_ENABLE;
  assign hit_sts = paddr == ADDR_IRQ_STATUS;
  assign hit_clr = paddr == ADDR_IRQ_CLEAR;

  always_comb begin
    sw_clr            = '0;
    if (wr && hit_a) begin
      sw_clr[7:0]     = pwdata[7:0];
    end
    if (wr && hit_b) begin
      sw_clr[15:8]    = pwdata[7:0];
    end
    hw_clr            = '0;
    hw_clr[BIT_POWER] = st_q.ctl[CTL_LEGACY_BIT] && main_power_off_by_button;
    clr_v             = sw_clr | hw_clr;
  end

  always_comb begin
    st_d           = st_q;
    st_d.cnt       = cnt_d;
    st_d.flt       = flt_d;
    st_d.ring_prev = {ring_indicate_port_b, ring_indicate_port_a};
    st_d.status    = (st_q.status & ~clr_v) | set_v;
    st_d.clr_pb    = wr && hit_b && pwdata[BIT_POWER - 8];
    st_d.clr_sb    = wr && hit_b && pwdata[BIT_SLEEP - 8];
    if (wr && hit_ctl) begin
      st_d.ctl     = pwdata[CTL_W-1:0];
    end
    if (wr && hit_en) begin
      st_d.irq_en  = pwdata[15:0];
    end
    // New events beat a same-cycle interrupt clear
    st_d.irq_sts   = (st_q.irq_sts & ~((wr && hit_clr) ? pwdata[15:0] : 16'h0000))
                     | (set_v & ~st_q.status);
    st_d.irq       = |(st_d.irq_sts & st_d.irq_en);
    // One-cycle access: ready follows every setup cycle
    st_d.ready     = setup;
    st_d.slverr    = setup && !(hit_a || hit_b || hit_ctl || hit_en || hit_sts || hit_clr);
    st_d.rdata     = '0;
    if (setup && !pwrite) begin
      case (1'b1)
        hit_a:   st_d.rdata = {24'h000000, st_q.status[7:0]};
        hit_b:   st_d.rdata = {24'h000000, st_q.status[15:8]};
        hit_ctl: st_d.rdata = {15'h0000, st_q.ctl};
        hit_en:  st_d.rdata = {16'h0000, st_q.irq_en};
        hit_sts: st_d.rdata = {16'h0000, st_q.irq_sts};
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.cnt       <= '0;
      st_q.flt       <= FLT_RESET;
      st_q.ring_prev <= RING_PREV_RESET;
      st_q.status    <= STATUS_RESET;
      st_q.irq_en    <= '0;
      st_q.irq_sts   <= '0;
      st_q.ctl       <= CTL_RESET;
      st_q.rdata     <= '0;
      st_q.ready     <= 1'b0;
      st_q.slverr    <= 1'b0;
      st_q.irq       <= 1'b0;
      st_q.clr_pb    <= 1'b0;
      st_q.clr_sb    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata                        = st_q.rdata;
  assign pready                        = st_q.ready;
  assign pslverr                       = st_q.slverr;
  assign wake_status                   = st_q.status;
  assign clear_fixed_power_button_flag = st_q.clr_pb;
  assign clear_fixed_sleep_button_flag = st_q.clr_sb;
  assign irq                           = st_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rd_setup(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_pin_forced(int unsigned p);
    port4_pin_input[p] == st_q.ctl[CTL_POL_LSB + p] &&
    !st_q.ctl[CTL_DBEN_LSB + p] && !(wr && hit_ctl);
  endsequence

  // Pulses and falling edges: one cycle high, then low
  sequence s_high_then_low(sig);
    sig ##1 !sig;
  endsequence

  AST_SET_LANDS: assert property ((set_v != 16'h0000) |=>
    ((st_q.status & $past(set_v)) == $past(set_v)))
    else $error("Event did not set its flag");

  AST_STICKY_HOLD: assert property (1'b1 |=>
    ((st_q.status & $past(st_q.status) & ~$past(clr_v)) ==
     ($past(st_q.status) & ~$past(clr_v))))
    else $error("Flag dropped without a clear");

  AST_READ_A: assert property (s_rd_setup(ADDR_GPIO_PORT4) |=>
    (pready && prdata == {24'h000000, $past(st_q.status[7:0])}))
    else $error("First register read mismatch");

  AST_READ_B: assert property (s_rd_setup(ADDR_BUTTONS_INPUTS) |=>
    (pready && prdata == {24'h000000, $past(st_q.status[15:8])}))
    else $error("Second register read mismatch");

  AST_PIN7: assert property (s_pin_forced(7) |-> ##2 st_q.status[7])
    else $error("Pin 7 active level not latched");

  AST_PIN0: assert property (s_pin_forced(0) |-> ##2 st_q.status[0])
    else $error("Pin 0 active level not latched");

  AST_W1C: assert property ((wr && hit_a && set_v[7:0] == 8'h00) |=>
    (st_q.status[7:0] == ($past(st_q.status[7:0]) & ~$past(pwdata[7:0]))))
    else $error("Write-one clear wrong");

  AST_W1C_B: assert property ((wr && hit_b && set_v[15:8] == 8'h00 &&
    hw_clr == 16'h0000) |=> (st_q.status[15:8] ==
    ($past(st_q.status[15:8]) & ~$past(pwdata[7:0]))))
    else $error("Second register write-one clear wrong");

  AST_RESET_ZERO: assert property (disable iff (1'b0) !presetn |->
    (wake_status == 16'h0000 && !irq))
    else $error("Flags not zero in reset");

  AST_POWER: assert property (!st_q.flt[FLT_POWER] |=> st_q.status[BIT_POWER])
    else $error("Power press not flagged");

  AST_FIXED_PB: assert property ((wr && hit_b && pwdata[BIT_POWER - 8]) |=>
    s_high_then_low(clear_fixed_power_button_flag))
    else $error("Companion power clear missing");

  AST_LEGACY: assert property ((hw_clr[BIT_POWER] && !set_v[BIT_POWER]) |=>
    !st_q.status[BIT_POWER])
    else $error("Legacy power clear failed");

  AST_SLEEP: assert property (!st_q.flt[FLT_SLEEP] |=> st_q.status[BIT_SLEEP])
    else $error("Sleep press not flagged");

  AST_FIXED_SB: assert property ((wr && hit_b && pwdata[BIT_SLEEP - 8]) |=>
    s_high_then_low(clear_fixed_sleep_button_flag))
    else $error("Companion sleep clear missing");

  AST_KEY3: assert property ((key3_event && !kbd_pm_key_mode &&
    !st_q.status[BIT_KEY3]) |=> !st_q.status[BIT_KEY3])
    else $error("Key 3 set outside key mode");

  AST_KEY3_SET: assert property ((key3_event && kbd_pm_key_mode) |=>
    st_q.status[BIT_KEY3])
    else $error("Key 3 not flagged in key mode");

  AST_KEY2: assert property ((key2_event && kbd_pm_key_mode) |=>
    st_q.status[BIT_KEY2])
    else $error("Key 2 not flagged in key mode");

  AST_KEY2_GATE: assert property ((key2_event && !kbd_pm_key_mode &&
    !st_q.status[BIT_KEY2]) |=> !st_q.status[BIT_KEY2])
    else $error("Key 2 set outside key mode");

  AST_KEY1: assert property (key1_event |=> st_q.status[BIT_KEY1])
    else $error("Key 1 event not flagged");

  // no key 1 flag without event
  AST_KEY1_QUIET: assert property ((!key1_event && !st_q.status[BIT_KEY1]) |=>
    !st_q.status[BIT_KEY1])
    else $error("Key 1 flag set with no event");

  AST_POINTER: assert property (pointer_event |=> st_q.status[BIT_POINTER])
    else $error("Pointer event not flagged");

  AST_RING_B: assert property (s_high_then_low(ring_indicate_port_b)
    |=> st_q.status[BIT_RING_B])
    else $error("Ring B fall not flagged");

  AST_RING_A: assert property (s_high_then_low(ring_indicate_port_a)
    |=> st_q.status[BIT_RING_A])
    else $error("Ring A fall not flagged");

  AST_SET_WINS: assert property ((set_v[BIT_POWER] && clr_v[BIT_POWER]) |=>
    st_q.status[BIT_POWER])
    else $error("Clear beat a same-cycle set");

endmodule : wake_event_status_regs

//--- verification/wake_event_status_regs_tb.sv
module wake_event_status_regs_tb import wake_event_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // Short debounce keeps the run brief
  localparam int DEB = 4;
  localparam int WT  = DEB + 4;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, pins;
  logic [31:0] pwdata, prdata, seed;
  logic        pready, pslverr, pwr_n, slp_n, off, kmode;
  logic        k3, k2, k1, ptr, ring_a, ring_b;
  logic [15:0] wake_status;
  logic        clr_pwr, clr_slp, irq;
  int          errors, num_checks;
  int          m;

  wake_event_status_regs #(.DEBOUNCE_CYCLES_P(DEB)) wake_event_status_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port4_pin_input(pins), .power_button_input_n(pwr_n), .sleep_button_input_n(slp_n),
    .main_power_off_by_button(off), .kbd_pm_key_mode(kmode), .key3_event(k3),
    .key2_event(k2), .key1_event(k1), .pointer_event(ptr),
    .ring_indicate_port_a(ring_a), .ring_indicate_port_b(ring_b),
    .wake_status(wake_status), .clear_fixed_power_button_flag(clr_pwr),
    .clear_fixed_sleep_button_flag(clr_slp), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Leading edge wait keeps psel from being assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that never answers
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(e, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, err);
  endtask : rd

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6000) @(posedge pclk);
    errors++;
    give_verdict();
  end

  initial begin
    logic [31:0] v;
    seed = 32'h5d7b8398;
    m = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pins} = '0;
    {off, kmode, k3, k2, k1, ptr} = '0;
    {pwr_n, slp_n, ring_a, ring_b} = 4'hf;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk(wake_status, 32'h0);
    rd(ADDR_GPIO_PORT4, 32'h0, 1'b0);
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    rd(8'h1c, 32'h0, 1'b1);
    // Random pin bursts, then random write-one masks
    for (int i = 0; i < 4; i++) begin
      v = xs();
      pins <= v[7:0];
      cyc(3);
      pins <= 8'h00;
      cyc(3);
      m = m | v[7:0];
      rd(ADDR_GPIO_PORT4, m[7:0], 1'b0);
      v = xs();
      wr(ADDR_GPIO_PORT4, {24'h0, v[7:0]});
      m = m & ~int'(v[7:0]);
      rd(ADDR_GPIO_PORT4, m[7:0], 1'b0);
    end
    wr(ADDR_GPIO_PORT4, 32'hff);
    m = 0;
    // Pin 7 made active low while idle low
    wr(ADDR_CONTROL, 32'h0007f);
    cyc(4);
    rd(ADDR_GPIO_PORT4, 32'h80, 1'b0);
    wr(ADDR_CONTROL, {15'h0, CTL_RESET});
    cyc(3);
    wr(ADDR_GPIO_PORT4, 32'h80);
    // Debounce on pin 0: short glitch ignored, long level taken
    wr(ADDR_CONTROL, 32'h001ff);
    pins <= 8'h01;
    cyc(DEB - 2);
    pins <= 8'h00;
    cyc(WT);
    rd(ADDR_GPIO_PORT4, 32'h0, 1'b0);
    pins <= 8'h01;
    cyc(WT);
    pins <= 8'h00;
    cyc(WT);
    rd(ADDR_GPIO_PORT4, 32'h01, 1'b0);
    wr(ADDR_GPIO_PORT4, 32'h01);
    wr(ADDR_CONTROL, {15'h0, CTL_RESET});
    // Clear while the level is still active
    pins <= 8'h01;
    cyc(3);
    wr(ADDR_GPIO_PORT4, 32'h01);
    rd(ADDR_GPIO_PORT4, 32'h01, 1'b0);
    pins <= 8'h00;
    cyc(3);
    wr(ADDR_GPIO_PORT4, 32'h01);
    rd(ADDR_GPIO_PORT4, 32'h0, 1'b0);
    // Ring falls set flags; a held low level does not set again
    ring_a <= 1'b0;
    ring_b <= 1'b0;
    cyc(3);
    rd(ADDR_BUTTONS_INPUTS, 32'h03, 1'b0);
    wr(ADDR_BUTTONS_INPUTS, 32'h03);
    cyc(3);
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    ring_a <= 1'b1;
    ring_b <= 1'b1;
    cyc(3);
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    // Keys 3 and 2 count only in key mode
    k3 <= 1'b1;
    k2 <= 1'b1;
    cyc(2);
    {k3, k2, k1, ptr} <= 4'h3;
    cyc(2);
    {k1, ptr} <= 2'h0;
    cyc(2);
    rd(ADDR_BUTTONS_INPUTS, 32'h0c, 1'b0);
    kmode <= 1'b1;
    {k3, k2} <= 2'h3;
    cyc(2);
    {k3, k2} <= 2'h0;
    cyc(2);
    rd(ADDR_BUTTONS_INPUTS, 32'h3c, 1'b0);
    wr(ADDR_BUTTONS_INPUTS, 32'h3c);
    // Buttons, with companion clear pulses
    {pwr_n, slp_n} <= 2'h0;
    cyc(WT);
    wr(ADDR_BUTTONS_INPUTS, 32'h80);
    rd(ADDR_BUTTONS_INPUTS, 32'hc0, 1'b0);
    {pwr_n, slp_n} <= 2'h3;
    cyc(WT);
    rd(ADDR_BUTTONS_INPUTS, 32'hc0, 1'b0);
    wr(ADDR_BUTTONS_INPUTS, 32'h80);
    @(posedge pclk);
    chk({clr_pwr, clr_slp}, 32'h2);
    wr(ADDR_BUTTONS_INPUTS, 32'h40);
    @(posedge pclk);
    chk({clr_pwr, clr_slp}, 32'h1);
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    // Legacy mode: button power-off clears the power flag
    wr(ADDR_CONTROL, 32'h100ff);
    pwr_n <= 1'b0;
    cyc(WT);
    pwr_n <= 1'b1;
    cyc(WT);
    rd(ADDR_BUTTONS_INPUTS, 32'h80, 1'b0);
    off <= 1'b1;
    cyc(1);
    off <= 1'b0;
    cyc(2);
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    wr(ADDR_CONTROL, {15'h0, CTL_RESET});
    // Interrupt raised, masked and cleared
    wr(ADDR_IRQ_CLEAR, 32'hffff);
    wr(ADDR_IRQ_ENABLE, 32'h100);
    cyc(2);
    chk(irq, 32'h0);
    ring_a <= 1'b0;
    cyc(3);
    chk(irq, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h100, 1'b0);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h100);
    cyc(2);
    chk(irq, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h100);
    cyc(2);
    chk(irq, 32'h0);
    ring_a <= 1'b1;
    cyc(2);
    chk(wake_status, 32'h0100);
    // Mid-run reset drops a standing flag
    presetn <= 1'b0;
    cyc(2);
    chk(wake_status, 32'h0);
    chk(irq, 32'h0);
    presetn <= 1'b1;
    rd(ADDR_BUTTONS_INPUTS, 32'h0, 1'b0);
    give_verdict();
  end

endmodule : wake_event_status_regs_tb
